/* File: dv/edge_request_controller_tb_top.sv */
// Self-checking testbench for the edge request controller
`timescale 1ns/1ns
`default_nettype none
module edge_request_controller_tb_top;
    logic        clk_sys;                                       // System clock
    logic        rst_n;                                         // Synchronous reset
    logic        psel;                                          // Bus select
    logic        penable;                                       // Access phase
    logic        pwrite;                                        // Write strobe
    logic [7:0]  paddr;                                         // Byte address
    logic [31:0] pwdata;                                        // Write data
    logic [31:0] prdata;                                        // Read data
    logic        pready;                                        // Ready, polled by bus task
    logic        pslverr;                                       // Error flag
    logic [31:0] line_in;                                       // Line levels
    logic        stop_mode;                                     // System stop state
    logic [31:0] event_pulse;                                   // Event outputs
    logic [31:0] irq_req;                                       // Request outputs
    logic [31:0] rd;                                            // Last read data
    logic        err;                                           // Last error flag
    int          failures;                                      // Mismatch count
    int          total_checks;                                  // Comparison count

    edge_request_controller u_edge_request_controller (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .stop_mode(stop_mode), .event_pulse(event_pulse), .irq_req(irq_req));
    line_source_model u_line_source_model (.clk_sys(clk_sys), .line_in(line_in));

    // Clock generator, 20 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // One bus transfer: setup, access, release after the sampled edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        psel = 1'b1; penable = 1'b0; pwrite = w; paddr = a; pwdata = d;
        @(negedge clk_sys);
        penable = 1'b1;
        @(posedge clk_sys);
        // Request stays up until ready is sampled high
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd  = prdata;
        err = pslverr;
        @(negedge clk_sys);
        psel = 1'b0; penable = 1'b0;
    endtask

    // Compare one 32-bit result
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Read a register and compare under a mask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0000_0000);
        check(name, exp, rd & m);
    endtask

    // Apply line levels, then let sampling and registering finish
    task automatic lines(input logic [31:0] v);
        u_line_source_model.set(v);
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        #100000;
        failures++;
        summarize();
    end

    // Main sequence
    initial
    begin
        failures = 0; total_checks = 0; rst_n = 1'b0; stop_mode = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        repeat (3) @(negedge clk_sys);
        check("ready in reset", 32'h0000_0000, {31'h0, pready});
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(8'(4 * i), 32'hFFFF_FFFF, (i == 0) ? erc_pkg::RST_IRQ_UNMASK : erc_pkg::RST_ZERO, "reset");
        rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
        check("unmapped err", 32'h0000_0001, {31'h0, err});
        check("ready", 32'h0000_0001, {31'h0, pready});
        // Lines: 0 rise, 1 rise event only, 2 fall, 3 both, 4/5 soft, 6/7 write collisions
        bus(1'b1, erc_pkg::OFF_IRQ_UNMASK, erc_pkg::INT_LINES | 32'h0000_00DD);
        bus(1'b1, erc_pkg::OFF_EVT_UNMASK, 32'h0000_0002);
        bus(1'b1, erc_pkg::OFF_RISE_SEL, 32'h0000_004B);
        bus(1'b1, erc_pkg::OFF_FALL_SEL, 32'h0000_008C);
        rd_chk(erc_pkg::OFF_FALL_SEL, 32'hFFFF_FFFF, 32'h0000_008C, "fall select");
        u_line_source_model.set(32'h0000_008B);
        @(negedge clk_sys);
        repeat (2) @(posedge clk_sys);
        #1;
        check("event", 32'h0000_0002, event_pulse);
        @(posedge clk_sys);
        #1;
        check("event end", 32'h0000_0000, event_pulse);
        check("irq edges", 32'h0000_000D, irq_req);
        rd_chk(erc_pkg::OFF_PENDING, 32'hFFFF_FFFD, 32'h0000_000D, "pending");
        bus(1'b1, erc_pkg::OFF_PENDING, 32'h0000_0000);
        rd_chk(erc_pkg::OFF_PENDING, 32'hFFFF_FFFD, 32'h0000_000D, "pending kept");
        bus(1'b1, erc_pkg::OFF_PENDING, 32'h0000_000F);
        #1;
        check("irq cleared", 32'h0000_0000, irq_req);
        lines(32'h0000_0083);
        check("irq both", 32'h0000_0008, irq_req);
        bus(1'b1, erc_pkg::OFF_PENDING, 32'h0000_0008);
        bus(1'b1, erc_pkg::OFF_SOFT_TRIG, 32'h0000_0030);
        repeat (2) @(posedge clk_sys);
        #1;
        check("irq soft", 32'h0000_0010, irq_req);
        rd_chk(erc_pkg::OFF_SOFT_TRIG, 32'hFFFF_FFFF, 32'h0000_0030, "soft");
        rd_chk(erc_pkg::OFF_PENDING, 32'hFFFF_FFFF, 32'h0000_0010, "pending soft");
        bus(1'b1, erc_pkg::OFF_PENDING, 32'h0000_0030);
        rd_chk(erc_pkg::OFF_SOFT_TRIG, 32'hFFFF_FFFF, 32'h0000_0000, "soft clear");
        // Edges that land on a select write are dropped
        u_line_source_model.set(32'h0000_00C3);
        bus(1'b1, erc_pkg::OFF_RISE_SEL, 32'h0000_004B);
        u_line_source_model.set(32'h0000_0043);
        bus(1'b1, erc_pkg::OFF_FALL_SEL, 32'h0000_008C);
        lines(32'h0000_0043);
        check("irq collide", 32'h0000_0000, irq_req);
        // Internal line 23 only answers in stop mode
        lines(32'h0080_0043);
        check("irq run", 32'h0000_0000, irq_req);
        @(negedge clk_sys);
        stop_mode = 1'b1;                                       // Driven off the sampling edge
        lines(32'h0080_0043);
        check("irq stop", 32'h0080_0000, irq_req);
        bus(1'b1, erc_pkg::OFF_IRQ_UNMASK, 32'h0000_00DD);
        #1;
        check("irq masked", 32'h0000_0000, irq_req);
        summarize();
    end
endmodule
`default_nettype wire

/* File: dv/line_source_model.sv */
// Behavioural model of the pins and wakeup sources feeding the request lines
`timescale 1ns/1ns
`default_nettype none
module line_source_model
(
    // Clock
    input  wire logic        clk_sys,
    // Driven line levels
    output logic      [31:0] line_in
);
    logic [31:0] next_q;                                        // Level to present at next falling edge

    // Power-up levels: lines 2 and 7 start high for falling-edge tests
    initial
    begin
        next_q  = 32'h0000_0084;
        line_in = 32'h0000_0084;
    end

    // Request a new set of levels
    task automatic set(input logic [31:0] v);
        // Scheduled, so a call on a falling edge never races the driver below
        next_q <= v;
    endtask

    // Levels change once per cycle, off the sampling edge, never glitching
    always @(negedge clk_sys)
    begin
        line_in <= next_q;
    end
endmodule
`default_nettype wire

/* File: rtl/edge_request_controller.sv */
// Edge request controller: per-line edge, event and interrupt logic with registers
//
// Function
// - Event mask bit gates event pulses
// - Control registers clear to zero on reset, except interrupt mask: internal lines unmasked
// - Rising select triggers event and interrupt
// - Falling select triggers event and interrupt
// - Both selects: either edge triggers
// - Rising edge during rise-select write ignored
// - Falling edge during fall-select write ignored
// - Software trigger write sets pending, raises request on unmasked lines
// - Software trigger clears with its pending flag
// - Selected edge sets external pending flag
// - Write one clears pending; zero keeps
// - Pending register clears to zero on reset
// - Interrupt mask gates each line request
// - Event pulses never set pending flags
// - Internal lines: rising event, level request, no flag, stop only
`timescale 1ns/1ns
`default_nettype none
module edge_request_controller
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Peripheral register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Request lines and system state
    input  wire logic [31:0] line_in,
    input  wire logic        stop_mode,
    // Outputs per line
    output logic      [31:0] event_pulse,
    output logic      [31:0] irq_req
);
    localparam logic [31:0] EXT = erc_pkg::EXT_LINES;          // External line set
    localparam logic [31:0] INT = erc_pkg::INT_LINES;          // Internal line set

    logic [31:0] imr_q;                                         // Interrupt unmask
    logic [31:0] emr_q;                                         // Event unmask
    logic [31:0] rsel_q;                                        // Rising select
    logic [31:0] fsel_q;                                        // Falling select
    logic [31:0] swt_q;                                         // Software trigger
    logic [31:0] pend_q;                                        // Pending flags
    logic [31:0] pend_d;                                        // Next pending flags
    logic [31:0] swt_d;                                         // Next software trigger
    logic [31:0] imr_d;                                         // Next interrupt unmask
    logic [31:0] rdata_q;                                       // Read data
    logic        err_q;                                         // Unmapped access
    logic        rdy_q;                                         // Ready flag
    logic [31:0] evt_q;                                         // Event pulses
    logic [31:0] irq_q;                                         // Interrupt requests
    logic        wr;                                            // Access-phase write
    logic        setup;                                         // Setup phase
    logic [31:0] rise_trig;                                     // Qualified rising triggers
    logic [31:0] fall_trig;                                     // Qualified falling triggers
    logic [31:0] sw_new;                                        // Fresh software triggers
    logic [31:0] pr_clr;                                        // Pending clear bits

    line_edge_if edges ();                                      // Edge carrier

    // Edge detector
    line_edge_detect u_detect
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .edges   (edges)
    );
    assign edges.lines = line_in;

    // Bus phase decode
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite;

    // Trigger qualification; a write to a select register masks its edge
    always_comb
    begin
        rise_trig = edges.rise & rsel_q & EXT;
        fall_trig = edges.fall & fsel_q & EXT;
        if (wr && paddr == erc_pkg::OFF_RISE_SEL)
        begin
            rise_trig = 32'h0000_0000;
        end
        if (wr && paddr == erc_pkg::OFF_FALL_SEL)
        begin
            fall_trig = 32'h0000_0000;
        end
    end

    // Software trigger and pending next state; set wins over clear
    always_comb
    begin
        sw_new = 32'h0000_0000;
        pr_clr = 32'h0000_0000;
        imr_d  = imr_q;
        if (wr && paddr == erc_pkg::OFF_SOFT_TRIG)
        begin
            sw_new = pwdata & ~swt_q & EXT;
        end
        if (wr && paddr == erc_pkg::OFF_PENDING)
        begin
            pr_clr = pwdata & EXT;
        end
        if (wr && paddr == erc_pkg::OFF_IRQ_UNMASK)
        begin
            imr_d = pwdata;
        end
        pend_d = (pend_q & ~pr_clr) | rise_trig | fall_trig | (sw_new & imr_q);
        swt_d  = (swt_q & ~pr_clr) | sw_new;
    end

    // Configuration registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            imr_q  <= erc_pkg::RST_IRQ_UNMASK;
            emr_q  <= erc_pkg::RST_ZERO;
            rsel_q <= erc_pkg::RST_ZERO;
            fsel_q <= erc_pkg::RST_ZERO;
        end
        else
        begin
            imr_q <= imr_d;
            if (wr && paddr == erc_pkg::OFF_EVT_UNMASK)
            begin
                emr_q <= pwdata;
            end
            // Reserved select positions are not stored
            if (wr && paddr == erc_pkg::OFF_RISE_SEL)
            begin
                rsel_q <= pwdata & EXT;
            end
            if (wr && paddr == erc_pkg::OFF_FALL_SEL)
            begin
                fsel_q <= pwdata & EXT;
            end
        end
    end

    // Software trigger and pending flags
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            swt_q  <= erc_pkg::RST_ZERO;
            pend_q <= erc_pkg::RST_PENDING;
        end
        else
        begin
            swt_q  <= swt_d;
            pend_q <= pend_d;
        end
    end

    // Event pulses and interrupt requests
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            evt_q <= 32'h0000_0000;
            irq_q <= 32'h0000_0000;
        end
        else
        begin
            // External events from edges or software, internal events from rising edges in stop mode; pending untouched
            evt_q <= (emr_q & (rise_trig | fall_trig | sw_new))
                   | (emr_q & INT & edges.rise & {32{stop_mode}});
            // External request from pending flag; internal from line level
            irq_q <= (pend_d & imr_d & EXT)
                   | (imr_d & INT & edges.level & {32{stop_mode}});
        end
    end

    // Bus slave: read data and error captured in setup phase
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
            rdy_q   <= 1'b0;
        end
        else
        begin
            rdy_q <= 1'b1;
            if (setup)
            begin
                err_q <= 1'b0;
                if (paddr == erc_pkg::OFF_IRQ_UNMASK)
                    rdata_q <= imr_q;
                else if (paddr == erc_pkg::OFF_EVT_UNMASK)
                    rdata_q <= emr_q;
                else if (paddr == erc_pkg::OFF_RISE_SEL)
                    rdata_q <= rsel_q;
                else if (paddr == erc_pkg::OFF_FALL_SEL)
                    rdata_q <= fsel_q;
                else if (paddr == erc_pkg::OFF_SOFT_TRIG)
                    rdata_q <= swt_q;
                else if (paddr == erc_pkg::OFF_PENDING)
                    rdata_q <= pend_q;
                else
                begin
                    rdata_q <= 32'h0000_0000;
                    err_q   <= 1'b1;
                end
            end
        end
    end

    assign prdata      = rdata_q;
    assign pslverr     = err_q;
    assign pready      = rdy_q;
    assign event_pulse = evt_q;
    assign irq_req     = irq_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence sw_write_s;
        wr && paddr == erc_pkg::OFF_SOFT_TRIG && (pwdata & ~swt_q & EXT & imr_q) != 0;
    endsequence
    sequence no_pr_write_s;
        !(wr && paddr == erc_pkg::OFF_PENDING);
    endsequence

    ctrl_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        $past(!rst_n) |-> emr_q == 0 && rsel_q == 0 && fsel_q == 0 && swt_q == 0)
        else $error("control register not zero after reset");
    edge_pending_a: assert property ((rise_trig | fall_trig) != 0
        |=> (pend_q & $past(rise_trig | fall_trig)) == $past(rise_trig | fall_trig))
        else $error("selected edge did not set pending flag");
    rise_write_a: assert property (wr && paddr == erc_pkg::OFF_RISE_SEL
        |=> (pend_q & ~$past(pend_q) & $past(edges.rise)) == 0)
        else $error("rising edge set pending during select write");
    fall_write_a: assert property (wr && paddr == erc_pkg::OFF_FALL_SEL
        |=> (pend_q & ~$past(pend_q) & $past(edges.fall)) == 0)
        else $error("falling edge set pending during select write");
    pend_clear_a: assert property (wr && paddr == erc_pkg::OFF_PENDING && rise_trig == 0
        && fall_trig == 0 |=> (pend_q & $past(pwdata)) == 0)
        else $error("pending flag not cleared by one write");
    sw_request_a: assert property (sw_write_s
        |=> (irq_q & $past(pwdata & ~swt_q & EXT & imr_q)) == $past(pwdata & ~swt_q & EXT & imr_q))
        else $error("software trigger raised no request");
    sw_hold_a: assert property (no_pr_write_s
        |=> (swt_q & $past(swt_q)) == $past(swt_q))
        else $error("software trigger dropped without pending clear");
    irq_gate_a: assert property (##1 (irq_q & EXT) == (pend_q & imr_q & EXT))
        else $error("external request differs from pending and mask");
    event_mask_a: assert property ((evt_q & ~$past(emr_q)) == 0)
        else $error("event pulse on masked line");
    internal_stop_a: assert property (!stop_mode |=> (irq_q & INT) == 0 && (evt_q & INT) == 0)
        else $error("internal line active outside stop mode");
    no_int_pend_a: assert property ((pend_q & INT) == 0)
        else $error("pending flag on internal line");
endmodule
`default_nettype wire

/* File: rtl/erc_pkg.sv */
// Constants shared by the edge request controller files
package erc_pkg;
    localparam int          LINES          = 32;                // Number of request lines
    localparam int          ADDR_W         = 8;                 // Register byte address width
    // Register byte offsets
    localparam logic [7:0]  OFF_IRQ_UNMASK = 8'h00;             // Interrupt mask
    localparam logic [7:0]  OFF_EVT_UNMASK = 8'h04;             // Event mask
    localparam logic [7:0]  OFF_RISE_SEL   = 8'h08;             // Rising select
    localparam logic [7:0]  OFF_FALL_SEL   = 8'h0C;             // Falling select
    localparam logic [7:0]  OFF_SOFT_TRIG  = 8'h10;             // Software trigger
    localparam logic [7:0]  OFF_PENDING    = 8'h14;             // Pending flags
    // Line classes: external lines are 31, 22..19 and 17..0
    localparam logic [31:0] EXT_LINES      = 32'h807B_FFFF;     // Edge-selectable lines
    localparam logic [31:0] INT_LINES      = 32'h7F84_0000;     // Internal lines: rising event, level request
    // Reset values
    localparam logic [31:0] RST_IRQ_UNMASK = 32'h7F84_0000;     // Internal lines unmasked
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;     // Other control registers
    localparam logic [31:0] RST_PENDING    = 32'h0000_0000;     // Pending flags after reset
endpackage

/* File: rtl/line_edge_detect.sv */
// Per-line edge detector on two successive samples
`timescale 1ns/1ns
`default_nettype none
module line_edge_detect
(
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    // Lines and edges
    line_edge_if.det    edges
);
    logic [31:0] samp_q;                                        // Current sample
    logic [31:0] prev_q;                                        // Previous sample

    // Sample each line and keep the prior sample
    genvar i;
    generate
        for (i = 0; i < erc_pkg::LINES; i++)
        begin : g_line
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    samp_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                end
                else
                begin
                    samp_q[i] <= edges.lines[i];
                    prev_q[i] <= samp_q[i];
                end
            end
            // Compare successive samples
            assign edges.rise[i] = samp_q[i] & ~prev_q[i];
            assign edges.fall[i] = ~samp_q[i] & prev_q[i];
        end
    endgenerate
    assign edges.level = samp_q;
endmodule
`default_nettype wire

/* File: rtl/line_edge_if.sv */
// Line samples and detected edges between controller and detector
`timescale 1ns/1ns
`default_nettype none
interface line_edge_if;
    logic [31:0] lines;                                         // Raw line levels
    logic [31:0] level;                                         // Latest sample
    logic [31:0] rise;                                          // Rising edge seen
    logic [31:0] fall;                                          // Falling edge seen
    modport det (input lines, output level, output rise, output fall);
    modport ctl (output lines, input level, input rise, input fall);
endinterface
`default_nettype wire
